// ---- testbench/pdv_regs_monitor.sv ----
// port checks for the pad drive and voltage register bank
// assumes it is bound to the bank and watches only its ports
module pdv_regs_monitor
  import pdv_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  input wire logic        domain6_level_pin,
  input wire logic [31:0] rdata,
  input wire logic [15:0] port2b_drive,
  input wire logic [15:0] port3a_drive,
  input wire logic [15:0] port3d_drive,
  input wire logic        osc_level,
  input wire logic        domain6_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // helpers
  logic        written_q;
  wire  [47:0] drv_all  = {port2b_drive, port3a_drive, port3d_drive};
  wire         unmapped = addr[11:9] != 3'h0;
  // until a write, domain 6 must still follow its pin
  always_ff @(posedge clock or posedge rst)
    if (rst)
      written_q <= 1'b0;
    else if (wr_strobe)
      written_q <= 1'b1;
  // ====================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_mask_half_zero: assert property (
    rdata[31:16] == 16'h0) else $error("mask half seen");
  a_unmapped_read: assert property (
    rd_strobe && unmapped |=> rdata == 32'h0) else $error("odd read");
  a_unmapped_write: assert property (
    wr_strobe && unmapped |-> ##2 $stable(drv_all)) else $error("odd wr");
  a_masked_hold: assert property (
    wr_strobe && wdata[31:16] == 16'h0 |-> ##2 $stable(drv_all))
    else $error("masked bits moved");
  a_readback_match: assert property (
    rd_strobe && addr == PDV_OFS_P2B |=> rdata[15:0] == port2b_drive)
    else $error("readback differs");
  a_d6_from_pin: assert property (
    !written_q && !$past(rst) |-> domain6_level == $past(domain6_level_pin))
    else $error("domain 6 off pin");
  a_osc_write: assert property (
    wr_strobe && addr == PDV_OFS_VSEL && wdata[23]
    |-> ##2 osc_level == $past(wdata[7], 2)) else $error("osc bit");
  a_drive_write: assert property (
    wr_strobe && addr == PDV_OFS_P3A && !$past(wr_strobe) |-> ##2
    port3a_drive == ($past(wdata[15:0], 2) & $past(wdata[31:16], 2)
    | $past(port3a_drive) & ~$past(wdata[31:16], 2))) else $error("p3a");
  c_vsel_write: cover property (wr_strobe && addr == PDV_OFS_VSEL);
  c_masked_write: cover property (wr_strobe && wdata[31:16] == 16'h0);
  c_unmapped_read: cover property (rd_strobe && unmapped);
endmodule

bind pdv_regs pdv_regs_monitor mon_u (.clock(clock), .rst(rst),
  .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .domain6_level_pin(domain6_level_pin),
  .rdata(rdata), .port2b_drive(port2b_drive),
  .port3a_drive(port3a_drive), .port3d_drive(port3d_drive),
  .osc_level(osc_level), .domain6_level(domain6_level));

// ---- testbench/tb.sv ----
// self-checking bench for the pad drive and voltage register bank
// assumes the bank is the only slave on its register port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pdv_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, pin = 1'b0;
  logic        wr_strobe = 1'b0, rd_strobe = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  wire  [31:0] rdata;
  wire  [15:0] d [7];
  wire  [6:0]  lv;
  logic [15:0] m [8];
  int          miscompares = 0, samples_checked = 0, cycles = 0;
  int          seed = 72, k;
  logic [11:0] ofs [8] = '{PDV_OFS_P2A, PDV_OFS_P2B, PDV_OFS_P2C,
    PDV_OFS_P3A, PDV_OFS_P3B, PDV_OFS_P3C, PDV_OFS_P3D, PDV_OFS_VSEL};
  logic [15:0] rv [8] = '{16'h5555, 16'h0000, 16'h1554, 16'h5555,
    16'h5555, 16'h5555, 16'h0055, 16'h0000};
  pdv_regs dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .domain6_level_pin(pin), .rdata(rdata), .port2a_drive(d[0]),
    .port2b_drive(d[1]), .port2c_drive(d[2]), .port3a_drive(d[3]),
    .port3b_drive(d[4]), .port3c_drive(d[5]), .port3d_drive(d[6]),
    .osc_level(lv[6]), .domain5_level(lv[5]), .domain4_level(lv[4]),
    .domain3_level(lv[3]), .domain2_level(lv[2]),
    .domain1_level(lv[1]), .domain6_level(lv[0]));
  initial
    forever #4 clock = ~clock;
  // ====================
  // bus tasks and checks
  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // 8 is a hole inside the bank, 9 lies far outside it
  function automatic logic [11:0] at(int i);
    return i < 8 ? ofs[i] : (i == 8 ? 12'h10c : 12'h90c);
  endfunction
  // always followed by a read, which drops the strobe
  task automatic wr(int i, logic [31:0] v);
    logic [15:0] mk;
    mk = v[31:16] & (i == 7 ? 16'h00ff : 16'hffff);
    @(posedge clock);
    wr_strobe <= 1'b1;
    addr      <= at(i);
    wdata     <= v;
    pin       <= v[5];
    if (i < 8)
      m[i] = m[i] & ~mk | v[15:0] & mk;
  endtask
  task automatic rd(int i);
    @(posedge clock);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b1;
    addr      <= at(i);
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(negedge clock);
    chk("rdata", rdata, i < 8 ? {16'h0, m[i]} : 32'h0);
    for (int j = 0; j < 7; j++)
      chk("drive", d[j], m[j]);
    chk("level", lv, {m[7][7:2], m[7][0] ? m[7][1] : pin});
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    m = rv;
    for (k = 0; k < 10; k++)
      rd(k);
  endtask
  // a hang counts as a mismatch
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      close_out();
    end
  end
  // ====================
  // scenarios
  initial
  begin
    do_reset();
    // every drive code on every pin of port3 group A
    for (k = 0; k < 4; k++)
    begin
      wr(3, {16'hffff, {8{k[1:0]}}});
      rd(3);
    end
    // zero mask, then only the two end bits enabled
    wr(0, 32'h0000_aaaa);
    rd(0);
    wr(2, 32'h8001_ffff);
    rd(2);
    // random masked writes, read straight after
    repeat (300)
    begin
      k = $unsigned($random(seed)) % 10;
      wr(k, $random(seed));
      rd(k);
    end
    // second reset in mid-run restores defaults
    // reset rises on a clock edge, not at the check's negedge
    @(posedge clock);
    do_reset();
    close_out();
  end
endmodule

// ---- verilog/pdv_field_split.sv ----
// splits a drive register into eight 2-bit pad strength codes
// assumes pin k sits at bits 2k+1:2k
module pdv_field_split
  import pdv_pkg::*;
(
  input  wire logic [15:0] packed_in,
  output logic      [1:0]  code [8]
);

  // ==========================================================
  // field extraction
  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_pin
      assign code[k] = packed_in[2*k+1 -: 2];
    end
  endgenerate

endmodule

// ---- verilog/pdv_mask_reg.sv ----
// one 16-bit register with per-bit write enables in the upper half
// assumes the caller decodes the address into wr_sel
module pdv_mask_reg
  import pdv_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] IMPL    = 16'hffff
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wr_sel,
  input  wire logic [31:0] wr_data,
  output logic      [15:0] value_q
);

  // ==========================================================
  // masked update
  logic [15:0] bit_en;
  logic [15:0] value_d;

  assign bit_en  = wr_sel ? (wr_data[31:16] & IMPL) : 16'h0000;
  assign value_d = (value_q & ~bit_en) | (wr_data[15:0] & bit_en);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      value_q <= RST_VAL;
    else
      value_q <= value_d;
  end

endmodule

// ---- verilog/pdv_pkg.sv ----
// package of offsets, field layouts and reset values for the pad bank
// assumes a plain one-cycle register port and byte addresses
package pdv_pkg;

  // ==========================================================
  // bus geometry
  localparam int          PDV_AW        = 12;
  localparam int          PDV_NDRV      = 7;
  localparam int          PDV_MASK_LSB  = 16;

  // ==========================================================
  // register offsets
  localparam logic [11:0] PDV_OFS_P2A   = 12'h100;
  localparam logic [11:0] PDV_OFS_P2B   = 12'h104;
  localparam logic [11:0] PDV_OFS_P2C   = 12'h108;
  localparam logic [11:0] PDV_OFS_P3A   = 12'h110;
  localparam logic [11:0] PDV_OFS_P3B   = 12'h114;
  localparam logic [11:0] PDV_OFS_P3C   = 12'h118;
  localparam logic [11:0] PDV_OFS_P3D   = 12'h11c;
  localparam logic [11:0] PDV_OFS_VSEL  = 12'h180;

  // ==========================================================
  // drive codes
  localparam logic [1:0]  PDV_DRV_2MA   = 2'h0;
  localparam logic [1:0]  PDV_DRV_4MA   = 2'h1;
  localparam logic [1:0]  PDV_DRV_8MA   = 2'h2;
  localparam logic [1:0]  PDV_DRV_12MA  = 2'h3;

  // ==========================================================
  // reset values, pin 7 in the top field
  localparam logic [15:0] PDV_RST_P2A   = 16'h5555;
  localparam logic [15:0] PDV_RST_P2B   = 16'h0000;
  localparam logic [15:0] PDV_RST_P2C   = 16'h1554;
  localparam logic [15:0] PDV_RST_P3A   = 16'h5555;
  localparam logic [15:0] PDV_RST_P3B   = 16'h5555;
  localparam logic [15:0] PDV_RST_P3C   = 16'h5555;
  localparam logic [15:0] PDV_RST_P3D   = 16'h0055;

  // ==========================================================
  // voltage select layout
  localparam int          PDV_VS_SRC    = 0;
  localparam int          PDV_VS_D6     = 1;
  localparam int          PDV_VS_D1     = 2;
  localparam int          PDV_VS_D2     = 3;
  localparam int          PDV_VS_D3     = 4;
  localparam int          PDV_VS_D4     = 5;
  localparam int          PDV_VS_D5     = 6;
  localparam int          PDV_VS_OSC    = 7;
  localparam logic [15:0] PDV_VS_IMPL   = 16'h00ff;
  localparam logic [15:0] PDV_RST_VSEL  = 16'h0000;

endpackage

// ---- verilog/pdv_regs.sv ----
// pad drive strength and io domain voltage register bank
// assumes plain register port, read data one cycle after read strobe
// What this block does
// - written lower bit n changes only when mask bit n+16 is one
// - mask bit zero leaves the stored bit as it was
// - eight 2-bit drive codes: 2, 4, 8, 12 mA to the pads
// - pin k field occupies bits 2k+1 down to 2k
// - port2 group B at 0x104, all fields reset to 0
// - port2 group C at 0x108, pins 1-6 reset 1, pins 0,7 reset 0
// - port3 group A at 0x110, all fields reset to 1
// - port3 group B at 0x114, all fields reset to 1
// - port3 group C at 0x118, all fields reset to 1
// - port3 group D at 0x11c, pins 4-7 reset 0, pins 0-3 reset 1
// - voltage register 0x180: bit7 osc, bits6-2 domains 5..1, bit1 d6
// - voltage bits: zero is 3.3 V, one is 1.8 V, reset zero
// - extra bit selects source of domain 6 voltage
// - source zero follows pin, one follows register bit; reset zero
// - port2 group A at 0x100, all fields reset to 1
module pdv_regs
  import pdv_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  input  wire logic        domain6_level_pin,
  output logic      [31:0] rdata,
  output logic      [15:0] port2a_drive,
  output logic      [15:0] port2b_drive,
  output logic      [15:0] port2c_drive,
  output logic      [15:0] port3a_drive,
  output logic      [15:0] port3b_drive,
  output logic      [15:0] port3c_drive,
  output logic      [15:0] port3d_drive,
  output logic             osc_level,
  output logic             domain5_level,
  output logic             domain4_level,
  output logic             domain3_level,
  output logic             domain2_level,
  output logic             domain1_level,
  output logic             domain6_level
);

  // ==========================================================
  // address decode
  localparam logic [11:0] OFS [PDV_NDRV] = '{
    PDV_OFS_P2A, PDV_OFS_P2B, PDV_OFS_P2C, PDV_OFS_P3A,
    PDV_OFS_P3B, PDV_OFS_P3C, PDV_OFS_P3D};
  localparam logic [15:0] RST [PDV_NDRV] = '{
    PDV_RST_P2A, PDV_RST_P2B, PDV_RST_P2C, PDV_RST_P3A,
    PDV_RST_P3B, PDV_RST_P3C, PDV_RST_P3D};

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  logic [PDV_NDRV-1:0] drv_wr;
  logic [PDV_NDRV-1:0] drv_hit;
  logic [15:0]         drv_val [PDV_NDRV];
  logic                vsel_hit;
  logic                vsel_wr;
  logic [15:0]         vsel_val;
  logic [1:0]          drv_code [PDV_NDRV][8];
  logic [15:0]         pad_nx   [PDV_NDRV];

  assign vsel_hit = hit(addr, PDV_OFS_VSEL);
  assign vsel_wr  = wr_strobe & vsel_hit;

  // ==========================================================
  // drive registers
  genvar r;
  generate
    for (r = 0; r < PDV_NDRV; r++)
    begin : g_drv
      assign drv_hit[r] = hit(addr, OFS[r]);
      assign drv_wr[r]  = wr_strobe & drv_hit[r];
      pdv_mask_reg #(
        .RST_VAL (RST[r]),
        .IMPL    (16'hffff)
      ) u_drv (
        .clock   (clock),
        .rst     (rst),
        .wr_sel  (drv_wr[r]),
        .wr_data (wdata),
        .value_q (drv_val[r])
      );
      pdv_field_split u_split (
        .packed_in (drv_val[r]),
        .code      (drv_code[r])
      );
      assign pad_nx[r] = {drv_code[r][7], drv_code[r][6],
                          drv_code[r][5], drv_code[r][4],
                          drv_code[r][3], drv_code[r][2],
                          drv_code[r][1], drv_code[r][0]};
    end
  endgenerate

  // ==========================================================
  // voltage select register
  // domain bit layout
  pdv_mask_reg #(
    .RST_VAL (PDV_RST_VSEL),
    .IMPL    (PDV_VS_IMPL)
  ) u_vsel (
    .clock   (clock),
    .rst     (rst),
    .wr_sel  (vsel_wr),
    .wr_data (wdata),
    .value_q (vsel_val)
  );

  // ==========================================================
  // read mux
  logic [15:0] rd_sel;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb
  begin
    rd_sel = vsel_hit ? (vsel_val & PDV_VS_IMPL) : 16'h0000;
    for (int i = 0; i < PDV_NDRV; i++)
      if (drv_hit[i])
        rd_sel = drv_val[i];
  end

  assign rdata_d = rd_strobe ? {16'h0000, rd_sel} : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // ==========================================================
  // pad ring outputs, registered
  // the pin is sampled once so the pad sees a flop, one cycle late
  logic        d6_d;
  logic [15:0] pad_q [PDV_NDRV];
  logic [7:0]  lvl_q;

  assign d6_d = vsel_val[PDV_VS_SRC] ? vsel_val[PDV_VS_D6]
                                     : domain6_level_pin;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < PDV_NDRV; i++)
        pad_q[i] <= RST[i];
      lvl_q <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < PDV_NDRV; i++)
        pad_q[i] <= pad_nx[i];
      lvl_q <= {vsel_val[7:2], d6_d, 1'b0};
    end
  end

  assign port2a_drive  = pad_q[0];
  assign port2b_drive  = pad_q[1];
  assign port2c_drive  = pad_q[2];
  assign port3a_drive  = pad_q[3];
  assign port3b_drive  = pad_q[4];
  assign port3c_drive  = pad_q[5];
  assign port3d_drive  = pad_q[6];
  assign osc_level     = lvl_q[PDV_VS_OSC];
  assign domain5_level = lvl_q[PDV_VS_D5];
  assign domain4_level = lvl_q[PDV_VS_D4];
  assign domain3_level = lvl_q[PDV_VS_D3];
  assign domain2_level = lvl_q[PDV_VS_D2];
  assign domain1_level = lvl_q[PDV_VS_D1];
  assign domain6_level = lvl_q[PDV_VS_D6];

endmodule
